// >>> design/fpgpio_defines.vh
/*
 constants for the four-pin open-drain gpio port with edge interrupts.
 assumes inclusion by bare name from the design files.
*/
// Notes on behaviour
// [R1] edge-select bit: 0 falling, 1 rising
// [R2] set mask bit suppresses that pin's interrupt
// [R3] mask and edge-select bits reset to zero
// [R4] direction bit: 0 input, 1 output; resets input
// [R5] output with value 1 pulls pin low
// [R6] never drive high; pull low or float
// [R7] input pin value bit shows sampled level
// [R8] writes to input pin value bits ignored
// [R9] software sets edge and mask for inputs
// [R10] synchronised edges set pending interrupt request
`ifndef FPGPIO_DEFINES_VH
`define FPGPIO_DEFINES_VH

`define FPGPIO_ADDR_W        8
`define FPGPIO_ADDR_EDGEMASK 8'h0F
`define FPGPIO_ADDR_DIRVAL   8'h10
`define FPGPIO_RST_EDGEMASK  8'h00
`define FPGPIO_RST_DIRVAL    8'h00
`define FPGPIO_NPINS         4
`define FPGPIO_MASK_LSB      0
`define FPGPIO_EDGE_LSB      4
`define FPGPIO_VAL_LSB       0
`define FPGPIO_DIR_LSB       4

`endif

// >>> design/fpgpio_pin.v
/*
 one pin: two-flop synchroniser, edge detect, open-drain output.
 assumes pin input synchronous enough for a two-flop chain.
*/
`include "fpgpio_defines.vh"
module fpgpio_pin (
    input  wire i_sys_clk,
    input  wire i_reset_n,
    input  wire i_pin,
    input  wire i_dir_out,
    input  wire i_value,
    input  wire i_rising,
    input  wire i_mask,
    output wire o_level,
    output wire o_edge,
    output wire o_pull_low
);
    reg sync1_q;
    reg sync2_q;
    reg prev_q;

    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q  <= 1'b1;
        end
        else
        begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign o_level    = sync2_q; // [R7]
    // edges only counted on input pins
    assign o_edge     = !i_dir_out && !i_mask && // [R2]
                        (i_rising ? (sync2_q && !prev_q) : (!sync2_q && prev_q)); // [R1] [R10]
    // only a pull-down exists, so high is never driven
    assign o_pull_low = i_dir_out && i_value; // [R5] [R6]
endmodule

// >>> design/fpgpio_top.v
/*
 gpio port top: two registers on the device's internal register port,
 four open-drain pins and one pending-interrupt request.
 assumes a single-cycle write strobe and combinational-address read port.
*/
`include "fpgpio_defines.vh"
module fpgpio_top (
    input  wire       i_sys_clk,
    input  wire       i_reset_n,
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    input  wire       i_irq_clear,
    output reg        o_irq_pending,
    input  wire [3:0] i_pin,
    output reg  [3:0] o_pin,
    output reg  [3:0] o_pin_oe
);
    reg  [7:0] edgemask_q;
    reg  [3:0] dir_q;
    reg  [3:0] outval_q;
    wire [3:0] level;
    wire [3:0] edge_hit;
    wire [3:0] pull_low;
    wire [3:0] val_view;
    reg  [7:0] rdata_d;
    // reset word kept whole, direction field cut out on purpose
    wire [7:0] rst_dirval;

    assign rst_dirval = `FPGPIO_RST_DIRVAL;

    genvar g;
    generate
        for (g = 0; g < `FPGPIO_NPINS; g = g + 1)
        begin : pins
            fpgpio_pin u_pin (
                .i_sys_clk  (i_sys_clk),
                .i_reset_n  (i_reset_n),
                .i_pin      (i_pin[g]),
                .i_dir_out  (dir_q[g]),
                .i_value    (outval_q[g]),
                .i_rising   (edgemask_q[`FPGPIO_EDGE_LSB + g]),
                .i_mask     (edgemask_q[`FPGPIO_MASK_LSB + g]),
                .o_level    (level[g]),
                .o_edge     (edge_hit[g]),
                .o_pull_low (pull_low[g])
            );
        end
    endgenerate

    // value bit reads the pin level for inputs, the stored value for outputs
    assign val_view = (dir_q & outval_q) | (~dir_q & level); // [R7]

    always @*
    begin
        case (i_reg_addr)
            `FPGPIO_ADDR_EDGEMASK: rdata_d = edgemask_q;
            `FPGPIO_ADDR_DIRVAL:   rdata_d = {dir_q, val_view};
            default:               rdata_d = 8'h00;
        endcase
    end

    always @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            edgemask_q    <= `FPGPIO_RST_EDGEMASK; // [R3]
            dir_q         <= rst_dirval[`FPGPIO_DIR_LSB +: 4]; // [R4]
            outval_q      <= 4'h0;
            o_reg_rdata   <= 8'h00;
            o_irq_pending <= 1'b0;
            o_pin         <= 4'h0;
            o_pin_oe      <= 4'h0;
        end
        else
        begin
            if (i_reg_wr && i_reg_addr == `FPGPIO_ADDR_EDGEMASK)
                edgemask_q <= i_reg_wdata; // [R1] [R2]
            if (i_reg_wr && i_reg_addr == `FPGPIO_ADDR_DIRVAL)
            begin
                dir_q <= i_reg_wdata[`FPGPIO_DIR_LSB +: 4]; // [R4]
                // input pins keep their bit; it is not stored, only viewed
                outval_q <= (i_reg_wdata[`FPGPIO_DIR_LSB +: 4] & i_reg_wdata[`FPGPIO_VAL_LSB +: 4])
                          | (~i_reg_wdata[`FPGPIO_DIR_LSB +: 4] & outval_q); // [R8]
            end
            if (i_reg_rd)
                o_reg_rdata <= rdata_d;
            // a new edge beats a clear in the same cycle
            o_irq_pending <= (|edge_hit) | (o_irq_pending & ~i_irq_clear); // [R10]
            o_pin    <= 4'h0; // [R6]
            o_pin_oe <= pull_low; // [R5]
        end
    end
endmodule

// >>> bench/fpgpio_chk.sv
/* checker on the gpio port pins and register port.
   assumes binding onto fpgpio_top. */
module fpgpio_chk (
    input wire logic       i_sys_clk, i_reset_n, i_reg_wr, i_reg_rd, i_irq_clear, o_irq_pending,
    input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
    input wire logic [3:0] i_pin, o_pin, o_pin_oe
);
    timeunit 1ns; timeprecision 1ps;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    logic [7:0] em_q;
    logic [3:0] dir_q;
    always @(posedge i_sys_clk)
        if (!i_reset_n) {em_q, dir_q} <= 12'h000;
        else if (i_reg_wr && i_reg_addr==8'h0F) em_q <= i_reg_wdata;
        else if (i_reg_wr && i_reg_addr==8'h10) dir_q <= i_reg_wdata[7:4];
    sequence s_wr; i_reg_wr && i_reg_addr==8'h10 ##1 !i_reg_wr; endsequence
    sequence s_rd; $stable(i_pin)[*3] ##0 i_reg_rd && i_reg_addr==8'h10 && dir_q==4'h0; endsequence
    property p_od; o_pin==4'h0; endproperty
    property p_rst; $past(!i_reset_n) |-> o_pin_oe==4'h0 && !o_irq_pending && o_reg_rdata==8'h00; endproperty
    property p_oe; s_wr |=> o_pin_oe==($past(i_reg_wdata,2)>>4 & $past(i_reg_wdata,2)); endproperty
    property p_in; s_rd |=> o_reg_rdata[3:0]==$past(i_pin); endproperty
    property p_msk; $rose(o_irq_pending) |-> $past(em_q[3:0])!=4'hF; endproperty
    property p_edg; $rose(o_irq_pending) |-> $past(i_pin,2)!=$past(i_pin,3) || $past(i_pin,3)!=$past(i_pin,4); endproperty
    property p_ris; $rose(o_irq_pending) && $past(em_q[7:4])==4'hF |-> |(~$past(i_pin,4) & $past(i_pin,2)); endproperty
    property p_fal; $rose(o_irq_pending) && $past(em_q[7:4])==4'h0 |-> |($past(i_pin,4) & ~$past(i_pin,2)); endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    a_rst: assert property (p_rst) else $error("reset state");
    a_oe: assert property (p_oe) else $error("pull-down enable");
    a_in: assert property (p_in) else $error("input level");
    a_msk: assert property (p_msk) else $error("masked irq");
    a_edg: assert property (p_edg) else $error("irq without edge");
    a_ris: assert property (p_ris) else $error("rising select");
    a_fal: assert property (p_fal) else $error("falling select");
endmodule
bind fpgpio_top fpgpio_chk chk_u (.*);

// >>> bench/fpgpio_ext.sv
/* far side: pull-ups on the pins plus external pull-down drivers.
   assumes oe high means the port sinks the pin. */
module fpgpio_ext (
    input  wire logic [3:0] i_oe,
    input  wire logic [3:0] i_drv_low,
    output wire logic [3:0] o_wire
);
    timeunit 1ns; timeprecision 1ps;
    assign o_wire = ~(i_oe | i_drv_low); // released pin floats to pull-up
endmodule

// >>> bench/testbench.sv
/* random and corner stimulus on the gpio port.
   assumes fpgpio_ext on the pins and the bound checker. */
module testbench;
    timeunit 1ns; timeprecision 1ps;
    logic clk=0, rst_n=0, wr=0, rd=0, clr=0;
    logic [7:0] addr=0, wd=0, d;
    logic [3:0] drv=0;
    wire [7:0] rdata;
    wire pend;
    wire [3:0] pin, po, oe;
    int failures=0, n_compared=0, seed=32'hbc5c;
    always #2 clk=~clk;
    fpgpio_top dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
        .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_irq_clear(clr), .o_irq_pending(pend), .i_pin(pin),
        .o_pin(po), .o_pin_oe(oe));
    fpgpio_ext ext_u (.i_oe(oe), .i_drv_low(drv), .o_wire(pin));
    task cyc(int n); repeat(n) @(posedge clk); #1; endtask
    task chk(logic [7:0] g, e);
        n_compared++;
        if (g!==e)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] exp_dirval(logic [7:0] w, logic [3:0] ext);
        exp_dirval = {w[7:4], (w[7:4] & w[3:0]) | (~w[7:4] & ~ext)};
    endfunction
    task wreg(logic [7:0] a, v); addr=a; wd=v; wr=1; cyc(1); wr=0; cyc(1); endtask
    task rreg(logic [7:0] a, e); addr=a; rd=1; cyc(1); rd=0; chk(rdata, e); cyc(1); endtask
    task stop_test;
        $display("failures=%0d compared=%0d", failures, n_compared);
        if (failures==0 && n_compared>0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #20000; failures++; stop_test;
    end
    initial
    begin
        cyc(5); rst_n=1; cyc(1);
        rreg(8'h0F, 8'h00);
        rreg(8'h10, 8'h0F);
        repeat(24)
        begin
            d=$random(seed); drv=$random(seed); wreg(8'h10, d); cyc(3);
            chk(oe, d[7:4]&d[3:0]);
            chk(po, 0);
            rreg(8'h10, exp_dirval(d, drv));
            d=$random(seed); wreg(8'h0F, d); rreg(8'h0F, d);
        end
        wreg(8'h11, 8'hFF); rreg(8'h0F, d);
        $display("register test done");
        wreg(8'h10, 8'h00);
        for (int i=0; i<4; i++)
        begin
            wreg(8'h0F, {{4{i[1]}}, {4{i[0]}}});
            drv={4{i[1]}}; cyc(4); clr=1; cyc(1); clr=0;
            drv=~drv; cyc(5); chk(pend, !i[0]);
            clr=1; cyc(1); clr=0;
            drv=~drv; cyc(5); chk(pend, 0);
        end
        $display("edge test done");
        stop_test;
    end
endmodule
